// [dv/radio_serial_register_bank_tb.sv]
// Testbench: APB-driven controller and register bank joined over the link
`timescale 1ns/1ps
`default_nettype none
module radio_serial_register_bank_tb
   import rsrb_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  en;
   logic        gain;
   logic        pump;
   logic [5:0]  refd;
   logic [6:0]  chan;
   logic [2:0]  on2;
   logic [2:0]  on1;
   logic [2:0]  bw;
   logic [1:0]  det;
   logic        sf;
   logic [3:0]  bias;
   logic [11:0] test;
   logic [15:0] wire_word = 16'h0000;
   logic [11:0] cur_en;
   logic [31:0] rd;
   logic        err;
   int          error_cnt = 0;
   int          n_compared = 0;
   ////////////////////////////////////////////////////////////////////////////
   rsrb_link_if rsrb_link_if_inst ();
   rsrb_ctrl rsrb_ctrl_inst (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .LINK(rsrb_link_if_inst));
   rsrb_bank rsrb_bank_inst (.CLK_I(clk), .RST_I(rst), .LINK(rsrb_link_if_inst), .AMP_BIAS_ON_O(en[9]),
      .TX_FILTER_ON_O(en[8]), .TX_UPCONV_ON_O(en[7]), .DETECTOR_ON_O(en[6]), .RX_DOWNCONV_ON_O(en[5]),
      .RX_LNA_ON_O(en[4]), .AUTOTUNER_ON_O(en[3]), .CHARGE_PUMP_ON_O(en[2]), .SYNTHESIZER_SETUP_LOOP_ON_O(en[1]),
      .OSCILLATOR_ON_O(en[0]), .LNA_HIGH_GAIN_O(gain), .PUMP_CURRENT_SEL_O(pump), .REF_DIVIDER_SEL_O(refd),
      .CHANNEL_SELECT_O(chan), .OFFSET_NULL_PARAM_TWO_O(on2), .OFFSET_NULL_PARAM_ONE_O(on1),
      .DETECTOR_MIDPOINT_SEL_O(det), .SPECIAL_FUNCTION_O(sf), .FILTER_CORNER_SEL_O(bw),
      .AMP_BIAS_LEVEL_O(bias), .TEST_WORD_O(test));
   rsrb_link_properties rsrb_link_properties_inst (.CLK_I(clk), .RST_I(rst),
      .frame_select_n(rsrb_link_if_inst.frame_select_n), .sclk(rsrb_link_if_inst.sclk),
      .sdata(rsrb_link_if_inst.sdata), .shutdown_n(rsrb_link_if_inst.shutdown_n),
      .transmit_on(rsrb_link_if_inst.transmit_on), .receive_on(rsrb_link_if_inst.receive_on),
      .lna_gain_select(rsrb_link_if_inst.lna_gain_select));
   ////////////////////////////////////////////////////////////////////////////
   initial forever #25 clk = ~clk;
   // Independent capture of the word as it crosses the wire
   always @(posedge rsrb_link_if_inst.sclk) if (!rsrb_link_if_inst.frame_select_n)
      wire_word <= {wire_word[14:0], rsrb_link_if_inst.sdata};
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for the slave as long as it takes; only the watchdog ends a hang
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Busy must read clear before the next word, or the word is dropped
   task automatic send(input logic [15:0] w);
      apb(1'b1, HREG_WORD, {16'h0, w});
      do apb(1'b0, HREG_STATUS, 32'h0); while (rd[0] !== 1'b0);
      repeat (8) @(posedge clk);
      cmp(wire_word, w);
   endtask
   function automatic logic [9:0] exp_en(input logic [11:0] e, input logic [3:0] m);
      return m[0] ? {e[10] | m[1], e[9] | m[1], e[8] | m[1], e[7] | m[2], e[6] | m[2], e[5] | m[2],
                     e[4] | m[1] | m[2], e[3:1]} : 10'h000;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      cmp({pump, refd, chan}, {1'b1, 6'h00, 7'h25});
      cmp({on2, on1, det, sf, bw}, RST_RECEIVE);
      cmp({bias, test}, {4'h0, TEST_PATTERN});
      cmp(en, 10'h000);
   endtask
   task automatic t_host;
      apb(1'b0, HREG_DIV, 32'h0);
      cmp(rd, {24'h0, DIV_RESET});
      apb(1'b1, HREG_DIV, 32'h0);
      apb(1'b0, HREG_DIV, 32'h0);
      cmp(rd, {24'h0, DIV_RESET});
      apb(1'b0, 12'h010, 32'h0);
      cmp(err, 1'b1);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 16; m++) begin
         apb(1'b1, HREG_CTRL, m);
         repeat (8) @(posedge clk);
         cmp(en, exp_en(cur_en, m[3:0]));
         cmp(gain, m[3]);
      end
      apb(1'b0, HREG_CTRL, 32'h0);
      cmp(rd, 32'h0000000f);
   endtask
   task automatic t_fields;
      send(16'h3063);
      cmp(chan, 7'd99);
      send(16'h2001);
      cmp({pump, refd}, 7'h01);
      send(16'h4fed);
      cmp({on2, on1, det, sf, bw}, 12'hfed);
      send(16'h5fff);
      cmp(bias, 4'hf);
      send(16'h6abc);
      cmp({chan, bias, test}, {7'd99, 4'hf, TEST_PATTERN});
      send(16'h0007);
      cmp(test, TEST_PATTERN);
      send(16'h1720);
      cur_en = 12'h720;
      t_modes;
   endtask
   task automatic t_shutdown;
      apb(1'b1, HREG_CTRL, 32'h6);
      repeat (8) @(posedge clk);
      cmp(chan, 7'd99);
      send(16'h3005);
      cmp({chan, en}, {7'd5, 10'h000});
      apb(1'b1, HREG_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      cmp({chan, en}, {7'd5, exp_en(cur_en, 4'h1)});
   endtask
   task automatic t_reset;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      t_defaults;
   endtask
   task automatic conclude;
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      t_defaults;
      t_host;
      cur_en = RST_ENABLE;
      t_modes;
      t_fields;
      t_shutdown;
      t_reset;
      conclude;
   end
   // Whole run is about 2000 cycles; limit is twenty times that
   initial begin
      #2000000;
      error_cnt++;
      conclude;
   end
endmodule
`default_nettype wire

// [dv/rsrb_link_properties.sv]
// Checker: wire-level properties of the three-wire link between the two ends
`timescale 1ns/1ps
`default_nettype none
module rsrb_link_properties (
   input  wire logic CLK_I,
   input  wire logic RST_I,
   input  wire logic frame_select_n,
   input  wire logic sclk,
   input  wire logic sdata,
   input  wire logic shutdown_n,
   input  wire logic transmit_on,
   input  wire logic receive_on,
   input  wire logic lna_gain_select
);
   ////////////////////////////////////////////////////////////////////////////
   logic [5:0] rise_cnt_q;
   logic       sclk_q;
   // Counts link clock rises per frame, cleared while idle
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rise_cnt_q <= 6'h00;
         sclk_q     <= 1'b0;
      end else begin
         sclk_q     <= sclk;
         rise_cnt_q <= frame_select_n ? 6'h00 : rise_cnt_q + {5'h00, sclk & ~sclk_q};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence frame_open;
      $fell(frame_select_n);
   endsequence
   sequence first_low;
      !sclk [*4] ##[1:2] sclk;
   endsequence
   idle_clk_low_a: assert property (frame_select_n |-> !sclk)
      else $error("link clock high outside a frame");
   data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
      else $error("data changed while link clock high");
   frame_lead_a: assert property (frame_open |-> first_low)
      else $error("first bit not set up before clock rise");
   high_phase_a: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
      else $error("link clock high phase not five cycles");
   low_phase_a: assert property ($fell(sclk) && !frame_select_n |-> !sclk [*5])
      else $error("link clock low phase too short");
   bit_count_a: assert property ($rose(frame_select_n) |-> rise_cnt_q == 6'd16)
      else $error("frame did not carry sixteen bits");
   frame_span_a: assert property (frame_open |-> ##[150:220] $rose(frame_select_n))
      else $error("frame length out of range");
   frame_gap_a: assert property ($rose(frame_select_n) |-> frame_select_n [*4])
      else $error("no idle gap after frame end");
endmodule
`default_nettype wire

// [logic/rsrb_bank.sv]
// Device end: serial shift register, register bank and block enable logic
`timescale 1ns/1ps
`default_nettype none
module rsrb_bank
   import rsrb_pkg::*;
(
   input  wire logic       CLK_I,
   input  wire logic       RST_I,
   rsrb_link_if.bank       LINK,
   output logic            AMP_BIAS_ON_O,
   output logic            TX_FILTER_ON_O,
   output logic            TX_UPCONV_ON_O,
   output logic            DETECTOR_ON_O,
   output logic            RX_DOWNCONV_ON_O,
   output logic            RX_LNA_ON_O,
   output logic            AUTOTUNER_ON_O,
   output logic            CHARGE_PUMP_ON_O,
   output logic            SYNTHESIZER_SETUP_LOOP_ON_O,
   output logic            OSCILLATOR_ON_O,
   output logic            LNA_HIGH_GAIN_O,
   output logic            PUMP_CURRENT_SEL_O,
   output logic [5:0]      REF_DIVIDER_SEL_O,
   output logic [6:0]      CHANNEL_SELECT_O,
   output logic [2:0]      OFFSET_NULL_PARAM_TWO_O,
   output logic [2:0]      OFFSET_NULL_PARAM_ONE_O,
   output logic [1:0]      DETECTOR_MIDPOINT_SEL_O,
   output logic            SPECIAL_FUNCTION_O,
   output logic [2:0]      FILTER_CORNER_SEL_O,
   output logic [3:0]      AMP_BIAS_LEVEL_O,
   output logic [11:0]     TEST_WORD_O
);
   // RST_I stands for the digital supply rising from zero
   logic [6:0]  s1_q;
   logic [6:0]  s2_q;
   logic        clk_prev_q;
   logic        fs_prev_q;
   logic [15:0] shift_q;
   logic [11:0] en_q;
   logic [11:0] syn_q;
   logic [11:0] chn_q;
   logic [11:0] rcv_q;
   logic [11:0] xmt_q;
   logic [11:0] tst_q;
   logic        sclk_rise;
   logic        frame_end;
   logic        sd_n;
   logic        tx_s;
   logic        rx_s;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers; the first stage feeds nothing else
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s1_q <= 7'h01;
         s2_q <= 7'h01;
      end else begin
         s1_q <= {LINK.lna_gain_select, LINK.receive_on, LINK.transmit_on,
                  LINK.shutdown_n, LINK.sdata, LINK.sclk, LINK.frame_select_n};
         s2_q <= s1_q;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         clk_prev_q <= 1'b0;
         fs_prev_q  <= 1'b1;
      end else begin
         clk_prev_q <= s2_q[1];
         fs_prev_q  <= s2_q[0];
      end
   end

   assign sclk_rise = s2_q[1] & ~clk_prev_q & ~s2_q[0];
   assign frame_end = s2_q[0] & ~fs_prev_q;
   assign sd_n      = s2_q[3];
   assign tx_s      = s2_q[4];
   assign rx_s      = s2_q[5];

   ////////////////////////////////////////////////////////////////////////
   // Shift register: oldest bit falls off, no length check
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         shift_q <= 16'h0000;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[14:0], s2_q[2]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register bank; writes accepted regardless of shutdown
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         en_q  <= RST_ENABLE;
         syn_q <= RST_SYNTHESIZER_SETUP;
         chn_q <= RST_CHANNEL;
         rcv_q <= RST_RECEIVE;
         xmt_q <= RST_TRANSMIT;
         tst_q <= TEST_PATTERN;
      end else if (frame_end) begin
         unique case (shift_q[WORD_W-1 -: ADDR_W])
            ADDR_TEST:     tst_q <= shift_q[DATA_W-1:0];
            ADDR_ENABLE:   en_q  <= shift_q[DATA_W-1:0];
            ADDR_SYNTHESIZER_SETUP:    syn_q <= shift_q[DATA_W-1:0];
            ADDR_CHANNEL:  chn_q <= shift_q[DATA_W-1:0];
            ADDR_RECEIVE:  rcv_q <= shift_q[DATA_W-1:0];
            ADDR_TRANSMIT: xmt_q <= shift_q[DATA_W-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Block enables, registered so outputs come from flip-flops
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         AMP_BIAS_ON_O    <= 1'b0;
         TX_FILTER_ON_O   <= 1'b0;
         TX_UPCONV_ON_O   <= 1'b0;
         DETECTOR_ON_O    <= 1'b0;
         RX_DOWNCONV_ON_O <= 1'b0;
         RX_LNA_ON_O      <= 1'b0;
         AUTOTUNER_ON_O   <= 1'b0;
         CHARGE_PUMP_ON_O <= 1'b0;
         SYNTHESIZER_SETUP_LOOP_ON_O  <= 1'b0;
         OSCILLATOR_ON_O  <= 1'b0;
         LNA_HIGH_GAIN_O  <= 1'b0;
      end else begin
         AMP_BIAS_ON_O    <= sd_n & (en_q[EN_AMP_BIAS] | tx_s);
         TX_FILTER_ON_O   <= sd_n & (en_q[EN_TX_FILT] | tx_s);
         TX_UPCONV_ON_O   <= sd_n & (en_q[EN_TX_UPC] | tx_s);
         DETECTOR_ON_O    <= sd_n & (en_q[EN_DET] | rx_s);
         RX_DOWNCONV_ON_O <= sd_n & (en_q[EN_RX_DNC] | rx_s);
         RX_LNA_ON_O      <= sd_n & (en_q[EN_RX_LNA] | rx_s);
         AUTOTUNER_ON_O   <= sd_n & (en_q[EN_AUTOTUNE] | rx_s | tx_s);
         CHARGE_PUMP_ON_O <= sd_n & en_q[EN_PUMP];
         SYNTHESIZER_SETUP_LOOP_ON_O  <= sd_n & en_q[EN_LOOP];
         OSCILLATOR_ON_O  <= sd_n & en_q[EN_OSC];
         LNA_HIGH_GAIN_O  <= s2_q[6];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field outputs straight from the bank flops
   always_comb begin
      PUMP_CURRENT_SEL_O      = syn_q[SY_PUMP_BIT];
      REF_DIVIDER_SEL_O       = syn_q[SY_REF_MSB:0];
      CHANNEL_SELECT_O        = chn_q[CH_MSB:0];
      OFFSET_NULL_PARAM_TWO_O = rcv_q[RX_ON2_LSB +: 3];
      OFFSET_NULL_PARAM_ONE_O = rcv_q[RX_ON1_LSB +: 3];
      DETECTOR_MIDPOINT_SEL_O = rcv_q[RX_DET_LSB +: 2];
      SPECIAL_FUNCTION_O      = rcv_q[RX_SF_BIT];
      FILTER_CORNER_SEL_O     = rcv_q[RX_BW_MSB:0];
      AMP_BIAS_LEVEL_O        = xmt_q[TX_PA_MSB:0];
      TEST_WORD_O             = tst_q;
   end
endmodule
`default_nettype wire

// [logic/rsrb_ctrl.sv]
// Controller end: APB slave that sends 16-bit words over the three-wire link
`timescale 1ns/1ps
`default_nettype none
module rsrb_ctrl
   import rsrb_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   rsrb_link_if.ctrl        LINK
);
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b11, ST_GAP = 2'b10} rsrb_st_t;
   rsrb_st_t    st_q;
   logic [15:0] word_q;
   logic [4:0]  bits_q;
   logic [7:0]  div_q;
   logic [7:0]  cnt_q;
   logic [3:0]  ctrl_q;
   logic        tick;
   logic        acc;
   logic        wr;
   logic        busy;

   assign acc  = PSEL_I & PENABLE_I;
   assign wr   = acc & PWRITE_I;
   assign busy = (st_q != ST_IDLE);
   assign tick = (cnt_q == div_q);

   ////////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, registered
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h00000000;
      end else begin
         PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
         PSLVERR_O <= 1'b0;
         PRDATA_O  <= 32'h00000000;
         if (acc & ~PREADY_O & ~PWRITE_I) begin
            unique case (PADDR_I)
               HREG_CTRL:   PRDATA_O <= {28'h0000000, ctrl_q};
               HREG_WORD:   PRDATA_O <= {16'h0000, word_q};
               HREG_STATUS: PRDATA_O <= {31'h00000000, busy};
               HREG_DIV:    PRDATA_O <= {24'h000000, div_q};
               default:     PSLVERR_O <= 1'b1;
            endcase
         end else if (acc & ~PREADY_O) begin
            PSLVERR_O <= (PADDR_I != HREG_CTRL) && (PADDR_I != HREG_WORD) && (PADDR_I != HREG_DIV);
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_q <= 4'h0;
         div_q  <= DIV_RESET;
      end else if (wr & PREADY_O) begin
         if (PADDR_I == HREG_CTRL) begin
            ctrl_q <= PWDATA_I[3:0];
         end
         if (PADDR_I == HREG_DIV && PWDATA_I[7:0] != 8'h00) begin
            div_q <= PWDATA_I[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Divider: half-period tick for the serial clock
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cnt_q <= 8'h00;
      end else if (!busy || tick) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer; a word write while busy is ignored
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_q   <= ST_IDLE;
         word_q <= 16'h0000;
         bits_q <= 5'h00;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (wr & PREADY_O && PADDR_I == HREG_WORD) begin
                  word_q <= PWDATA_I[15:0];
                  bits_q <= 5'h10;
                  st_q   <= ST_LOW;
               end
            end
            ST_LOW: if (tick) begin
               st_q <= ST_HIGH;
            end
            ST_HIGH: if (tick) begin
               word_q <= {word_q[14:0], 1'b0};
               bits_q <= bits_q - 5'h01;
               st_q   <= (bits_q == 5'h01) ? ST_GAP : ST_LOW;
            end
            ST_GAP: if (tick) begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link pins from flops; data changes while clock is low
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         LINK.frame_select_n  <= 1'b1;
         LINK.sclk            <= 1'b0;
         LINK.sdata           <= 1'b0;
         LINK.shutdown_n      <= 1'b0;
         LINK.transmit_on     <= 1'b0;
         LINK.receive_on      <= 1'b0;
         LINK.lna_gain_select <= 1'b0;
      end else begin
         LINK.frame_select_n  <= ~(st_q == ST_LOW || st_q == ST_HIGH);
         LINK.sclk            <= (st_q == ST_HIGH);
         LINK.sdata           <= word_q[15];
         LINK.shutdown_n      <= ctrl_q[CTRL_SHDN_N];
         LINK.transmit_on     <= ctrl_q[CTRL_TX_ON];
         LINK.receive_on      <= ctrl_q[CTRL_RX_ON];
         LINK.lna_gain_select <= ctrl_q[CTRL_GAIN];
      end
   end
endmodule
`default_nettype wire

// [logic/rsrb_link_if.sv]
// Interface: three-wire serial link plus mode pins between controller and bank
`timescale 1ns/1ps
`default_nettype none
interface rsrb_link_if;
   logic frame_select_n;
   logic sclk;
   logic sdata;
   logic shutdown_n;
   logic transmit_on;
   logic receive_on;
   logic lna_gain_select;
   modport ctrl (output frame_select_n, output sclk, output sdata, output shutdown_n,
                 output transmit_on, output receive_on, output lna_gain_select);
   modport bank (input frame_select_n, input sclk, input sdata, input shutdown_n,
                 input transmit_on, input receive_on, input lna_gain_select);
endinterface
`default_nettype wire

// [logic/rsrb_pkg.sv]
// Package: register map, field layout and timing constants for the serial register bank
package rsrb_pkg;
   localparam int          WORD_W       = 16;
   localparam int          ADDR_W       = 4;
   localparam int          DATA_W       = 12;
   localparam logic [3:0]  ADDR_TEST    = 4'h0;
   localparam logic [3:0]  ADDR_ENABLE  = 4'h1;
   localparam logic [3:0]  ADDR_SYNTHESIZER_SETUP   = 4'h2;
   localparam logic [3:0]  ADDR_CHANNEL = 4'h3;
   localparam logic [3:0]  ADDR_RECEIVE = 4'h4;
   localparam logic [3:0]  ADDR_TRANSMIT= 4'h5;
   localparam logic [11:0] RST_ENABLE   = 12'h01e;
   localparam logic [11:0] RST_SYNTHESIZER_SETUP    = 12'h040;
   localparam logic [11:0] RST_CHANNEL  = 12'h025;
   localparam logic [11:0] RST_RECEIVE  = 12'hfd2;
   localparam logic [11:0] RST_TRANSMIT = 12'h000;
   localparam logic [11:0] TEST_PATTERN = 12'h007;
   // Enable bit positions
   localparam int EN_AMP_BIAS = 10;
   localparam int EN_TX_FILT  = 9;
   localparam int EN_TX_UPC   = 8;
   localparam int EN_DET      = 7;
   localparam int EN_RX_DNC   = 6;
   localparam int EN_RX_LNA   = 5;
   localparam int EN_AUTOTUNE = 4;
   localparam int EN_PUMP     = 3;
   localparam int EN_LOOP     = 2;
   localparam int EN_OSC      = 1;
   // Field positions
   localparam int SY_PUMP_BIT = 6;
   localparam int SY_REF_MSB  = 5;
   localparam int CH_MSB      = 6;
   localparam int RX_ON2_LSB  = 9;
   localparam int RX_ON1_LSB  = 6;
   localparam int RX_DET_LSB  = 4;
   localparam int RX_SF_BIT   = 3;
   localparam int RX_BW_MSB   = 2;
   localparam int TX_PA_MSB   = 3;
   // Host register map (APB, byte addresses)
   localparam logic [11:0] HREG_CTRL   = 12'h000;
   localparam logic [11:0] HREG_WORD   = 12'h004;
   localparam logic [11:0] HREG_STATUS = 12'h008;
   localparam logic [11:0] HREG_DIV    = 12'h00c;
   localparam logic [7:0]  DIV_RESET   = 8'h04;
   localparam int          CTRL_SHDN_N = 0;
   localparam int          CTRL_TX_ON  = 1;
   localparam int          CTRL_RX_ON  = 2;
   localparam int          CTRL_GAIN   = 3;
   localparam logic [3:0]  FRAME_GAP   = 4'h4;
endpackage
